// ==== src/pps_sequencer.sv ====
// push-button power sequencer: press timing, rail order, reset, alarms
//
// Overview of operation
// - short press: reset low, release plus 64ms
// - long press: rails off, defaults, on after release
// - after power cycle, 128ms for power_hold
// - button_state_out driven low while pressed
// - startup reset held timeout after buck_one good
// - interrupt_out low on any unmasked condition
// - interrupt sources masked at reset, writable
// - button release without power_hold shuts down
// - start on resistive press or charger
// - buck_three, ldo_five first, then reset low
// - buck_one 2ms, buck_two 4ms, ldo_four 8ms
// - delays within (T-1ms)x88% to Tx112%
// - reset released at timeout if buck_three good
// - ldo_six, ldo_seven follow aux_ldo_enable when up
// - master_off write of 1 shuts down
// - slave only, address 1011011x, 400kHz
// - threshold code 0000..1111, default 0111
// - system_supply_low_flag shows supply below threshold
// - alarm mode: interrupt until recovery and read
// - lockout mode: supply drop turns rails off
// - over-temperature disables rails until cooled
// - buck fault interrupt until recovered and read
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "pps_consts.svh"

module pps_sequencer #(
    parameter int unsigned CYC_PER_MS = `PPS_CYC_PER_MS
) (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // push-button and system pins
    input  wire logic       pushbutton_in_n_i,
    input  wire logic       pb_resistive_i,
    input  wire logic       charger_input_i,
    input  wire logic       power_hold_i,
    input  wire logic       aux_ldo_enable_i,
    // analog monitors
    input  wire pps_pkg::pps_ana_t ana_i,
    // register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // regulator control
    output logic      [6:0] reg_en_o,
    output logic      [3:0] system_supply_threshold_sel_o,
    // open-drain pins, low while enable high
    output logic            reset_out_oe_o,
    output logic            button_state_oe_o,
    output logic            interrupt_out_oe_o
);

    localparam logic [16:0] DIV_LAST = 17'(CYC_PER_MS - 1);
    // slave address for the outside serial engine, slave only
    localparam logic [6:0]  SLAVE_ADDR = `PPS_SLAVE_ADDR;

    pps_pkg::pps_state_t q;
    pps_pkg::pps_state_t d;

    logic pressed;
    logic direct;
    logic tick;
    logic off_req;
    logic restore;
    logic b3_l5_good;
    logic rd_sys;
    logic rd_pg;

    always_comb begin
        d          = q;
        off_req    = 1'b0;
        restore    = 1'b0;
        pressed    = !pushbutton_in_n_i;
        direct     = pressed && !pb_resistive_i;
        tick       = (q.div == DIV_LAST);
        b3_l5_good = ana_i.pgood[`PPS_B3] && ana_i.pgood[`PPS_L5];
        rd_sys     = reg_rd_i && (reg_addr_i == `PPS_REG_SYS);
        rd_pg      = reg_rd_i && (reg_addr_i == `PPS_REG_PGOOD);
        d.rdata    = 8'h00;

        // millisecond timebase
        if (tick) begin
            d.div = 17'h00000;
        end else begin
            d.div = q.div + 17'h00001;
        end

        unique case (q.st)
            pps_pkg::ST_OFF: begin
                d.div    = 17'h00000;
                d.en     = 7'h00;
                d.rst_oe = 1'b1;
                d.ms     = 8'h00;
                d.rto    = 8'h00;
                // cooled die and healthy supply needed to start
                if ((pressed || charger_input_i) &&
                    !ana_i.over_temp && !ana_i.system_supply_below) begin
                    d.st       = pps_pkg::ST_START;
                    d.pb_start = pressed && !charger_input_i;
                    d.hold_win = 1'b0;
                end
            end
            pps_pkg::ST_START: begin
                d.en[`PPS_B3] = 1'b1;
                d.en[`PPS_L5] = 1'b1;
                d.ms          = 8'h00;
                d.rto         = 8'h00;
                if (b3_l5_good) begin
                    d.st     = pps_pkg::ST_SEQ;
                    d.rst_oe = 1'b1;
                end
            end
            pps_pkg::ST_SEQ: begin
                // restart on loss of buck_three or ldo_five power-good
                if (!b3_l5_good) begin
                    d.ms = 8'h00;
                end else if (tick && q.ms != `PPS_MS_MAX) begin
                    d.ms = q.ms + 8'h01;
                end
                if (q.ms >= `PPS_B1_MS) begin
                    d.en[`PPS_B1] = 1'b1;
                end
                if (q.ms >= `PPS_B2_MS) begin
                    d.en[`PPS_B2] = 1'b1;
                end
                if (q.ms >= `PPS_L4_MS) begin
                    d.en[`PPS_L4] = 1'b1;
                end
                if (!ana_i.pgood[`PPS_B1]) begin
                    d.rto = 8'h00;
                end else if (tick && q.rto != `PPS_RST_TO_MS) begin
                    d.rto = q.rto + 8'h01;
                end
                if (q.rto == `PPS_RST_TO_MS && q.ms >= `PPS_L4_MS &&
                    ana_i.pgood[`PPS_B3]) begin
                    d.st     = pps_pkg::ST_RUN;
                    d.rst_oe = 1'b0;
                    d.ms     = 8'h00;
                end
            end
            pps_pkg::ST_RUN: begin
                d.en[`PPS_L6] = aux_ldo_enable_i;
                d.en[`PPS_L7] = aux_ldo_enable_i;
                if (q.hold_win) begin
                    if (tick) begin
                        d.ms = q.ms + 8'h01;
                    end
                    if (power_hold_i) begin
                        d.hold_win = 1'b0;
                    end else if (q.ms >= `PPS_HOLD_WIN_MS) begin
                        off_req = 1'b1;
                    end
                end else if (direct && !q.pb_start) begin
                    d.st     = pps_pkg::ST_PRESS;
                    d.rst_oe = 1'b1;
                    d.ms     = 8'h00;
                end
            end
            pps_pkg::ST_PRESS: begin
                d.rst_oe = 1'b1;
                if (tick && q.ms != `PPS_MS_MAX) begin
                    d.ms = q.ms + 8'h01;
                end
                if (!pressed) begin
                    d.st = pps_pkg::ST_WARM;
                    d.ms = 8'h00;
                end else if (q.ms > `PPS_SHORT_MS) begin
                    d.st    = pps_pkg::ST_COLD;
                    d.en    = 7'h00;
                    restore = 1'b1;
                end
            end
            pps_pkg::ST_WARM: begin
                d.rst_oe = 1'b1;
                if (pressed) begin
                    d.st = pps_pkg::ST_PRESS;
                    d.ms = 8'h00;
                end else begin
                    if (tick) begin
                        d.ms = q.ms + 8'h01;
                    end
                    if (q.ms >= `PPS_WARM_MS) begin
                        d.st     = pps_pkg::ST_RUN;
                        d.rst_oe = 1'b0;
                        d.ms     = 8'h00;
                    end
                end
            end
            pps_pkg::ST_COLD: begin
                d.en     = 7'h00;
                d.rst_oe = 1'b1;
                if (!pressed) begin
                    d.st       = pps_pkg::ST_START;
                    d.pb_start = 1'b0;
                    d.hold_win = 1'b1;
                end
            end
        endcase

        // button released before the processor took over
        if (q.pb_start && !pressed) begin
            d.pb_start = 1'b0;
            if (!power_hold_i) begin
                off_req = 1'b1;
            end
        end

        // register writes
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                `PPS_REG_SYS: begin
                    d.thr     = reg_wdata_i[`PPS_SYS_THR_LSB +: 4];
                    d.amode   = reg_wdata_i[`PPS_SYS_MODE_BIT];
                    d.aunmask = reg_wdata_i[`PPS_SYS_UNM_BIT];
                end
                `PPS_REG_CTRL: begin
                    if (reg_wdata_i[`PPS_CTRL_OFF_BIT]) begin
                        off_req = 1'b1;
                    end
                end
                `PPS_REG_FMASK: begin
                    d.funmask = reg_wdata_i[2:0];
                end
                default: begin
                end
            endcase
        end

        // register reads, data in the following cycle
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `PPS_REG_SYS: begin
                    d.rdata = {1'b0, ana_i.system_supply_below, q.aunmask,
                               q.amode, q.thr};
                end
                `PPS_REG_FMASK: begin
                    d.rdata = {5'h00, q.funmask};
                end
                `PPS_REG_PGOOD: begin
                    d.rdata = {1'b0, ana_i.pgood};
                end
                default: begin
                    d.rdata = 8'h00;
                end
            endcase
        end

        // supply alarm, set wins over the read clear
        if (q.st != pps_pkg::ST_OFF && ana_i.system_supply_below) begin
            if (!q.amode) begin
                off_req = 1'b1;
            end
        end
        d.virq = (q.amode && q.aunmask && ana_i.system_supply_below) ||
                 (q.virq && !(rd_sys && !ana_i.system_supply_below));

        // buck fault latches
        for (int i = 0; i < 3; i++) begin
            d.firq[i] = (q.funmask[i] && q.en[i] && !ana_i.pgood[i]) ||
                        (q.firq[i] &&
                         !(rd_pg && (!q.en[i] || ana_i.pgood[i])));
        end

        if (ana_i.over_temp && q.st != pps_pkg::ST_OFF) begin
            off_req = 1'b1;
        end

        if (off_req) begin
            d.st       = pps_pkg::ST_OFF;
            d.en       = 7'h00;
            d.rst_oe   = 1'b1;
            d.pb_start = 1'b0;
            d.hold_win = 1'b0;
            restore    = 1'b1;
        end

        // power-up defaults, interrupt sources masked
        if (restore) begin
            d.thr     = `PPS_THR_RST;
            d.amode   = `PPS_MODE_RST;
            d.aunmask = `PPS_UNM_RST;
            d.funmask = `PPS_FUNM_RST;
            d.virq    = 1'b0;
            d.firq    = 3'h0;
        end

        d.btn_oe = pressed;
        d.irq_oe = d.virq || (|d.firq);
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q          <= '0;
            q.st       <= pps_pkg::ST_OFF;
            q.rst_oe   <= 1'b1;
            q.thr      <= `PPS_THR_RST;
            q.amode    <= `PPS_MODE_RST;
            q.aunmask  <= `PPS_UNM_RST;
            q.funmask  <= `PPS_FUNM_RST;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata_o          = q.rdata;
    assign reg_en_o             = q.en;
    assign system_supply_threshold_sel_o = q.thr;
    assign reset_out_oe_o       = q.rst_oe;
    assign button_state_oe_o    = q.btn_oe;
    assign interrupt_out_oe_o   = q.irq_oe;

endmodule
`default_nettype wire

// ==== src/pps_consts.svh ====
// constants of the push-button power sequencer
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH

// timebase
`define PPS_MCLK_HZ       125000000
`define PPS_MS_PER_S      1000
`define PPS_CYC_PER_MS    (`PPS_MCLK_HZ / `PPS_MS_PER_S)

// press, reset and sequencing times in ms
`define PPS_SHORT_MS      8'd130
`define PPS_WARM_MS       8'd64
`define PPS_HOLD_WIN_MS   8'd128
`define PPS_RST_TO_MS     8'd64
`define PPS_B1_MS         8'd2
`define PPS_B2_MS         8'd4
`define PPS_L4_MS         8'd8
`define PPS_MS_MAX        8'hff

// regulator bit positions in the enable and power-good vectors
`define PPS_B1            0
`define PPS_B2            1
`define PPS_B3            2
`define PPS_L4            3
`define PPS_L5            4
`define PPS_L6            5
`define PPS_L7            6

// register offsets
`define PPS_REG_SYS       8'h00
`define PPS_REG_CTRL      8'h01
`define PPS_REG_FMASK     8'h02
`define PPS_REG_PGOOD     8'h03

// field positions of the supply and control registers
`define PPS_SYS_THR_LSB   0
`define PPS_SYS_MODE_BIT  4
`define PPS_SYS_UNM_BIT   5
`define PPS_SYS_LOW_BIT   6
`define PPS_CTRL_OFF_BIT  0

// reset values
`define PPS_THR_RST       4'h7
`define PPS_MODE_RST      1'b1
`define PPS_UNM_RST       1'b0
`define PPS_FUNM_RST      3'h0

// serial slave address for the outside protocol engine
`define PPS_SLAVE_ADDR    7'h5b

`endif

// ==== src/pps_pkg.sv ====
// types of the push-button power sequencer
package pps_pkg;

    typedef enum logic [6:0] {
        ST_OFF   = 7'h01,
        ST_START = 7'h02,
        ST_SEQ   = 7'h04,
        ST_RUN   = 7'h08,
        ST_PRESS = 7'h10,
        ST_WARM  = 7'h20,
        ST_COLD  = 7'h40
    } pps_fsm_t;

    typedef struct packed {
        logic [6:0] pgood;
        logic       system_supply_below;
        logic       over_temp;
    } pps_ana_t;

    typedef struct packed {
        pps_fsm_t    st;
        logic [16:0] div;
        logic [7:0]  ms;
        logic [7:0]  rto;
        logic        pb_start;
        logic        hold_win;
        logic [3:0]  thr;
        logic        amode;
        logic        aunmask;
        logic [2:0]  funmask;
        logic        virq;
        logic [2:0]  firq;
        logic [6:0]  en;
        logic        rst_oe;
        logic        btn_oe;
        logic        irq_oe;
        logic [7:0]  rdata;
    } pps_state_t;

endpackage

// ==== testbench/pps_far_model.sv ====
// processor and rail stand-in for the sequencer's far side
`timescale 1ns/100ps
`default_nettype none
module pps_far_model (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // from the sequencer, and hold_en_i from the bench
    input  wire logic [6:0] en_i,
    input  wire logic       rst_oe_i,
    input  wire logic       hold_en_i,
    // to the sequencer
    output var  logic [6:0] pgood_o,
    output var  logic       hold_o
);
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pgood_o <= 7'h00;
            hold_o  <= 1'b0;
        end else begin
            pgood_o <= en_i;
            hold_o  <= hold_en_i & ~rst_oe_i & (|en_i);
        end
    end
endmodule
`default_nettype wire

// ==== testbench/pps_sequencer_checker.sv ====
// port assertions of the push-button power sequencer
`timescale 1ns/100ps
`default_nettype none
module pps_sequencer_checker #(
    parameter int unsigned CYC_PER_MS = 4
) (
    input wire logic              mclk_i,
    input wire logic              rst_n_i,
    input wire logic              pushbutton_in_n_i,
    input wire logic              aux_ldo_enable_i,
    input wire pps_pkg::pps_ana_t ana_i,
    input wire logic              reg_rd_i,
    input wire logic [6:0]        reg_en_o,
    input wire logic              reset_out_oe_o,
    input wire logic              button_state_oe_o,
    input wire logic              interrupt_out_oe_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_core_on;
        $rose(reg_en_o[2]) ##0 reg_en_o[4];
    endsequence
    sequence s_b1_wait;
        !reg_en_o[0] [*4];
    endsequence
    AST_BTN_LOW: assert property (
        !pushbutton_in_n_i |=> button_state_oe_o)
        else $error("button state not driven");
    AST_B1_ORDER: assert property ($rose(reg_en_o[0]) |-> reg_en_o[2]
        && reg_en_o[4] && ana_i.pgood[2]) else $error("buck one early");
    AST_B1_DELAY: assert property (s_core_on |=> s_b1_wait)
        else $error("buck one delay short");
    AST_RAIL_ORDER: assert property (
        $rose(reg_en_o[3]) |-> reg_en_o[1:0] == 2'h3)
        else $error("rail order wrong");
    AST_RST_REL: assert property ($fell(reset_out_oe_o) |-> ana_i.pgood[2]
        && reg_en_o[0]) else $error("reset freed without rails");
    AST_OFF_RST: assert property (reg_en_o == 7'h00 |-> reset_out_oe_o)
        else $error("reset free while off");
    AST_HOT_OFF: assert property (ana_i.over_temp |=> reg_en_o == 7'h00)
        else $error("rails on while hot");
    AST_AUX: assert property ($rose(reg_en_o[5]) |-> $past(aux_ldo_enable_i))
        else $error("aux rail without enable");
    AST_IRQ_CLR: assert property (
        $fell(interrupt_out_oe_o) |-> $past(reg_rd_i) || reset_out_oe_o)
        else $error("interrupt dropped without read");
endmodule
bind pps_sequencer pps_sequencer_checker #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .pushbutton_in_n_i(pushbutton_in_n_i),
    .aux_ldo_enable_i(aux_ldo_enable_i), .ana_i(ana_i), .reg_rd_i(reg_rd_i),
    .reg_en_o(reg_en_o), .reset_out_oe_o(reset_out_oe_o),
    .button_state_oe_o(button_state_oe_o),
    .interrupt_out_oe_o(interrupt_out_oe_o));
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench of the push-button power sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int CPM = 4;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, pb_n = 1'b1, pb_res = 1'b0;
    logic chg = 1'b0, aux = 1'b0, hold_en = 1'b1, below = 1'b0, hot = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    logic wr = 1'b0, rd = 1'b0;
    wire logic [7:0] rdata;
    wire logic [6:0] en, pg;
    wire logic [3:0] thr;
    wire logic rst_oe, btn_oe, irq_oe, hold;
    pps_pkg::pps_ana_t ana;
    int num_errors = 0, cmp_count = 0, n, t, k;
    logic [7:0] exp_sys = 8'h17;
    assign ana = {pg, below, hot};
    always #4 mclk_i = ~mclk_i;
    pps_sequencer #(.CYC_PER_MS(CPM)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .pushbutton_in_n_i(pb_n), .pb_resistive_i(pb_res),
        .charger_input_i(chg), .power_hold_i(hold), .aux_ldo_enable_i(aux),
        .ana_i(ana), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_en_o(en),
        .system_supply_threshold_sel_o(thr), .reset_out_oe_o(rst_oe),
        .button_state_oe_o(btn_oe), .interrupt_out_oe_o(irq_oe));
    pps_far_model far (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .en_i(en),
        .rst_oe_i(rst_oe), .hold_en_i(hold_en), .pgood_o(pg), .hold_o(hold));
    task automatic end_sim;
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        if (a == 8'h00)
            exp_sys = d & 8'h3f;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        @(negedge mclk_i);
        check(rdata, exp);
        @(posedge mclk_i);
    endtask
    function automatic logic probe(input int s);
        return s < 7 ? en[s] : rst_oe;
    endfunction
    task automatic wait_hi(input int s, input logic v, output int c);
        c = 0;
        @(negedge mclk_i);
        while (probe(s) !== v && c < 3000) begin
            @(negedge mclk_i);
            c++;
        end
        @(posedge mclk_i);
        if (c >= 3000)
            check(8'h00, 8'h01);
    endtask
    task automatic hold_cyc(input int c, input logic [6:0] exp);
        repeat (c) @(posedge mclk_i);
        @(negedge mclk_i);
        check({1'b0, en}, {1'b0, exp});
        @(posedge mclk_i);
    endtask
    function automatic logic win(input int c, input int tn);
        return c * 100 >= (tn - 1) * 88 * CPM - 100
            && c * 100 <= tn * 112 * CPM + 300;
    endfunction
    task automatic boot(input int rail_t);
        chg <= 1'b1;
        wait_hi(2, 1'b1, n);
        wait_hi(0, 1'b1, t);
        check({7'h0, win(t + 1, 2) & rail_t[0]}, {7'h0, rail_t[0]});
        wait_hi(1, 1'b1, n);
        t += n + 1;
        check({7'h0, win(t, 4) & rail_t[0]}, {7'h0, rail_t[0]});
        wait_hi(3, 1'b1, n);
        t += n + 1;
        check({7'h0, win(t, 8) & rail_t[0]}, {7'h0, rail_t[0]});
        wait_hi(7, 1'b0, n);
        hold_cyc(0, 7'h1f);
        chg <= 1'b0;
    endtask
    task automatic press(input int c, input logic r);
        pb_n <= 1'b0;
        pb_res <= r;
        repeat (c) @(posedge mclk_i);
        pb_n <= 1'b1;
        pb_res <= 1'b0;
    endtask
    initial begin
        #160000;
        check(8'h00, 8'h01);
        end_sim();
    end
    initial begin
        void'($urandom(12));
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        rd_reg(8'h00, 8'h17);
        rd_reg(8'h02, 8'h00);
        wr_reg(8'h10, 8'hff);
        rd_reg(8'h10, 8'h00);
        for (k = 0; k < 16; k++) begin
            wr_reg(8'h00, {4'h1, k[3:0]});
            @(negedge mclk_i);
            check({4'h0, thr}, {4'h0, k[3:0]});
            @(posedge mclk_i);
            rd_reg(8'h00, exp_sys);
        end
        boot(1);
        rd_reg(8'h03, 8'h1f);
        aux <= 1'b1;
        hold_cyc(3, 7'h7f);
        aux <= 1'b0;
        hold_cyc(3, 7'h1f);
        pb_n <= 1'b0;
        repeat (2) @(posedge mclk_i);
        @(negedge mclk_i);
        check({6'h0, btn_oe, rst_oe}, 8'h03);
        @(posedge mclk_i);
        press(8 + $urandom % 200, 1'b0);
        wait_hi(7, 1'b0, n);
        check({7'h0, n >= 248 && n <= 266}, 8'h01);
        check({7'h0, btn_oe}, 8'h00);
        wr_reg(8'h00, 8'h37);
        below <= 1'b1;
        repeat (3) @(posedge mclk_i);
        @(negedge mclk_i);
        check({7'h0, irq_oe}, 8'h01);
        @(posedge mclk_i);
        rd_reg(8'h00, exp_sys | 8'h40);
        below <= 1'b0;
        repeat (3) @(posedge mclk_i);
        @(negedge mclk_i);
        check({7'h0, irq_oe}, 8'h01);
        @(posedge mclk_i);
        rd_reg(8'h00, exp_sys);
        @(negedge mclk_i);
        check({7'h0, irq_oe}, 8'h00);
        @(posedge mclk_i);
        press(140 * CPM, 1'b0);
        @(negedge mclk_i);
        check({1'b0, en}, 8'h00);
        wait_hi(7, 1'b0, n);
        rd_reg(8'h00, 8'h17);
        hold_cyc(140 * CPM, 7'h1f);
        hold_en <= 1'b0;
        press(140 * CPM, 1'b0);
        wait_hi(7, 1'b0, n);
        hold_cyc(0, 7'h1f);
        hold_cyc(128 * CPM + 20, 7'h00);
        pb_n <= 1'b0;
        pb_res <= 1'b1;
        wait_hi(7, 1'b0, n);
        press(1, 1'b1);
        hold_cyc(4, 7'h00);
        hold_en <= 1'b1;
        pb_n <= 1'b0;
        pb_res <= 1'b1;
        wait_hi(7, 1'b0, n);
        press(4, 1'b1);
        hold_cyc(4, 7'h1f);
        wr_reg(8'h01, 8'h01);
        @(negedge mclk_i);
        check({rst_oe, en}, 8'h80);
        @(posedge mclk_i);
        boot(0);
        hot <= 1'b1;
        chg <= 1'b1;
        hold_cyc(20, 7'h00);
        hot <= 1'b0;
        chg <= 1'b0;
        end_sim();
    end
endmodule
`default_nettype wire
